// ---- core/alc_gain_ctrl.sv ----
// Level control and peak limiter gain controller
// Overview of operation
// R1: Disable freezes gain at last controlled value
// R2: Host changes gain via manual gain field
// R3: Host clears mute and zero cross first
// R4: Normal mode holds level near threshold
// R5: Limiter lowers gain on peaks above threshold
// R6: Limiter never raises above starting gain
// R7: Enable in limiter mode captures starting gain
// R8: Normal-to-limiter switch captures current gain
// R9: Fall rate field paces gain reductions
// R10: Rise rate field paces gain increases
// R11: Limiter mode uses shorter step intervals
// R12: Each code times one gain step
// R13: Step timing scales with sample rate
// R14: Zero cross gate delays gain changes
// R15: Mode bit selects normal or limiter
// R16: Below threshold steps gain up
// R17: Above threshold steps gain down
// R18: Runs only while enable bit set
// R19: Hold delays rises, doubles per code
// R20: Rate codes double, saturate at ten
//
// The implementer's own choice: strobed register access.
module alc_gain_ctrl #(
   parameter int GAIN_W = 6,
   parameter int TIM_W  = 20
) (
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [8:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [8:0]        reg_rdata,
   input  wire logic [2:0]        sample_rate_select,
   input  wire logic              level_above,
   input  wire logic              zero_cross,
   output logic      [GAIN_W-1:0] amp_gain,
   output logic                   input_amp_mute
);

   initial begin
      if (GAIN_W != 6 || TIM_W < 18) begin
         $error("alc_gain_ctrl: unsupported GAIN_W or TIM_W");
      end
   end

   logic [8:0]        cfg_reg;
   logic [8:0]        hold_reg;
   logic [8:0]        mode_reg;
   logic [8:0]        zc_reg;
   logic [8:0]        gain_reg;
   logic [GAIN_W-1:0] start_gain;
   logic              en_q;
   logic              mode_q;
   logic [TIM_W-1:0]  tcnt;
   logic              unit_tick;
   logic              step_due;
   logic              step_go;
   alc_pkg::alc_state_t state;
   alc_pkg::alc_state_t next_state;

   wire level_control_enable = cfg_reg[alc_pkg::EN_BIT];
   wire limiter_mode_select  = mode_reg[alc_pkg::MODE_BIT];
   wire zero_cross_gate      = zc_reg[alc_pkg::ZC_BIT];
   wire [3:0] hold_time_select = hold_reg[alc_pkg::HOLD_LSB +: 4];
   wire [3:0] gain_rise_rate   = mode_reg[alc_pkg::RISE_LSB +: 4];
   wire [3:0] gain_fall_rate   = mode_reg[alc_pkg::FALL_LSB +: 4];
   wire [GAIN_W-1:0] manual_input_gain = gain_reg[alc_pkg::GAIN_LSB +: GAIN_W];
   wire [GAIN_W-1:0] min_code = {cfg_reg[alc_pkg::MIN_LSB +: 3], alc_pkg::GAIN_FILL_LO};
   wire [GAIN_W-1:0] max_code = {cfg_reg[alc_pkg::MAX_LSB +: 3], alc_pkg::GAIN_FILL_HI};
   wire wr_gain = reg_wr && reg_addr == alc_pkg::ADDR_GAIN;

   // Interval for a rate code, doubling and saturating at ten
   function automatic logic [TIM_W-1:0] interval(input int base, input logic [3:0] code);
      logic [3:0] c;
      c = (code > alc_pkg::CODE_SAT) ? alc_pkg::CODE_SAT : code; // R20
      return TIM_W'(base) << c; // R12
   endfunction : interval

   // Hold length: zero for code zero, else doubles from HOLD_UNIT (235 units)
   function automatic logic [TIM_W-1:0] hold_len(input logic [3:0] code);
      logic [3:0] c;
      c = (code > alc_pkg::CODE_SAT) ? alc_pkg::CODE_SAT : code;
      if (c == 4'h0) begin
         return '0;
      end
      return TIM_W'(alc_pkg::HOLD_UNIT) << (c - 4'h1); // R19
   endfunction : hold_len

   // Limiter ceiling is the captured gain, unless max is lower
   wire [GAIN_W-1:0] ceiling = (limiter_mode_select && start_gain < max_code) ? start_gain : max_code; // R6

   // Faster units in limiter mode for the same code
   wire [TIM_W-1:0] fall_ivl = limiter_mode_select ? interval(alc_pkg::LIM_FALL_UNIT, gain_fall_rate)
                                                   : interval(alc_pkg::NRM_FALL_UNIT, gain_fall_rate); // R9 R11 R15
   wire [TIM_W-1:0] rise_ivl = limiter_mode_select ? interval(alc_pkg::LIM_RISE_UNIT, gain_rise_rate)
                                                   : interval(alc_pkg::NRM_RISE_UNIT, gain_rise_rate); // R10 R11 R15

   // ***************************************************
   // Time base
   // ***************************************************
   alc_unit_tick #(
      .CNT_W (12)
   ) u_tick (
      .sys_clk            (sys_clk),
      .sys_rst            (sys_rst),
      .sample_rate_select (sample_rate_select), // R13
      .unit_tick          (unit_tick)
   );

   // ***************************************************
   // Register writes
   // ***************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_reg  <= alc_pkg::RST_CFG;
         hold_reg <= alc_pkg::RST_HOLD;
         mode_reg <= alc_pkg::RST_MODE;
         zc_reg   <= alc_pkg::RST_ZC;
         gain_reg <= alc_pkg::RST_GAIN;
      end else if (reg_wr) begin
         case (reg_addr)
            alc_pkg::ADDR_CFG:  cfg_reg  <= reg_wdata;
            alc_pkg::ADDR_HOLD: hold_reg <= reg_wdata;
            alc_pkg::ADDR_MODE: mode_reg <= reg_wdata;
            alc_pkg::ADDR_ZC:   zc_reg   <= reg_wdata;
            alc_pkg::ADDR_GAIN: gain_reg <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Read data valid the cycle after the strobe; unmapped reads zero
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            alc_pkg::ADDR_CFG:  reg_rdata <= cfg_reg;
            alc_pkg::ADDR_HOLD: reg_rdata <= hold_reg;
            alc_pkg::ADDR_MODE: reg_rdata <= mode_reg;
            alc_pkg::ADDR_ZC:   reg_rdata <= zc_reg;
            alc_pkg::ADDR_GAIN: reg_rdata <= gain_reg;
            alc_pkg::ADDR_STAT: reg_rdata <= 9'({state, amp_gain});
            default:            reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   assign input_amp_mute = gain_reg[alc_pkg::MUTE_BIT];

   // ***************************************************
   // Starting gain capture
   // ***************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         en_q       <= 1'b0;
         mode_q     <= 1'b0;
         start_gain <= '0;
      end else begin
         en_q   <= level_control_enable;
         mode_q <= limiter_mode_select;
         if (level_control_enable && !en_q && limiter_mode_select) begin
            start_gain <= amp_gain; // R7
         end else if (level_control_enable && en_q && limiter_mode_select && !mode_q) begin
            start_gain <= amp_gain; // R8
         end
      end
   end

   // ***************************************************
   // Direction state machine
   // ***************************************************
   always_comb begin
      next_state = state;
      case (state)
         alc_pkg::ALC_IDLE: next_state = level_above ? alc_pkg::ALC_FALL : alc_pkg::ALC_HOLD;
         alc_pkg::ALC_FALL: if (!level_above) next_state = alc_pkg::ALC_HOLD; // R16
         alc_pkg::ALC_HOLD: begin
            if (level_above) begin
               next_state = alc_pkg::ALC_FALL; // R17
            end else if (tcnt >= hold_len(hold_time_select)) begin
               next_state = alc_pkg::ALC_RISE;
            end
         end
         alc_pkg::ALC_RISE: if (level_above) next_state = alc_pkg::ALC_FALL; // R17
         default: next_state = alc_pkg::ALC_IDLE;
      endcase
      if (!level_control_enable) begin
         next_state = alc_pkg::ALC_IDLE; // R18
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= alc_pkg::ALC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Unit counter restarts on every state change and applied step
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tcnt <= '0;
      end else if (next_state != state || step_go) begin
         tcnt <= '0;
      end else if (unit_tick && !step_due) begin
         tcnt <= tcnt + 1'b1;
      end
   end

   assign step_due = (state == alc_pkg::ALC_FALL && tcnt >= fall_ivl) ||
                     (state == alc_pkg::ALC_RISE && tcnt >= rise_ivl);
   // A due step waits for a crossing when the gate is on
   assign step_go  = step_due && next_state == state && (!zero_cross_gate || zero_cross); // R14

   // ***************************************************
   // Gain register
   // ***************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         amp_gain <= alc_pkg::RST_GAIN[GAIN_W-1:0];
      end else if (!level_control_enable) begin
         if (wr_gain) begin
            amp_gain <= reg_wdata[alc_pkg::GAIN_LSB +: GAIN_W]; // R2
         end
      end else if (step_go && state == alc_pkg::ALC_FALL && amp_gain > min_code) begin
         amp_gain <= amp_gain - 1'b1; // R5 R4
      end else if (step_go && state == alc_pkg::ALC_RISE && amp_gain < ceiling) begin
         amp_gain <= amp_gain + 1'b1; // R4 R6
      end
   end

   // ***************************************************
   // Checks
   // ***************************************************
   a_freeze_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !level_control_enable && !wr_gain |=> $stable(amp_gain)) // R1
      else $error("gain moved while control disabled");
   a_manual_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !level_control_enable && wr_gain |=> amp_gain == $past(reg_wdata[GAIN_W-1:0])) // R2
      else $error("manual gain not loaded");
   a_limit_ceiling: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $past(level_control_enable) && $past(limiter_mode_select) && amp_gain > $past(amp_gain)
      |-> amp_gain <= $past(start_gain)) // R6
      else $error("limiter raised gain above start");
   a_capture_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
      level_control_enable && !en_q && limiter_mode_select |=> start_gain == $past(amp_gain)) // R7
      else $error("start gain not captured at enable");
   a_mode_switch: assert property (@(posedge sys_clk) disable iff (sys_rst)
      level_control_enable && en_q && limiter_mode_select && !mode_q
      |=> start_gain == $past(amp_gain)) // R8
      else $error("start gain not captured at switch");
   a_fall_cause: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $past(level_control_enable) && amp_gain < $past(amp_gain)
      |-> $past(level_above) && $past(state) == alc_pkg::ALC_FALL && amp_gain >= min_code) // R5 R17
      else $error("gain fell without peak");
   a_rise_cause: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $past(level_control_enable) && amp_gain > $past(amp_gain)
      |-> !$past(level_above) && $past(state) == alc_pkg::ALC_RISE) // R16 R10
      else $error("gain rose without quiet input");
   a_zero_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $past(level_control_enable) && $past(zero_cross_gate) && $changed(amp_gain)
      |-> $past(zero_cross)) // R14
      else $error("gain changed off a crossing");
   a_off_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !level_control_enable |=> state == alc_pkg::ALC_IDLE) // R18
      else $error("controller active while disabled");
   a_fall_pace: assert property (@(posedge sys_clk) disable iff (sys_rst)
      step_go && state == alc_pkg::ALC_FALL |-> tcnt >= fall_ivl) // R9 R11
      else $error("fall step taken early");
   c_limit_fall: cover property (@(posedge sys_clk) disable iff (sys_rst)
      limiter_mode_select && step_go && state == alc_pkg::ALC_FALL);
   c_hold_rise: cover property (@(posedge sys_clk) disable iff (sys_rst)
      state == alc_pkg::ALC_HOLD ##1 state == alc_pkg::ALC_RISE);
   c_mode_switch: cover property (@(posedge sys_clk) disable iff (sys_rst)
      level_control_enable && en_q && limiter_mode_select && !mode_q);

endmodule : alc_gain_ctrl

// ---- core/alc_pkg.sv ----
// Shared constants for the level control gain block
package alc_pkg;

   // ***************************************************
   // Register map
   // ***************************************************
   localparam logic [7:0] ADDR_CFG  = 8'h20; // Enable, max and min gain
   localparam logic [7:0] ADDR_HOLD = 8'h21; // Hold time and threshold
   localparam logic [7:0] ADDR_MODE = 8'h22; // Mode, rise and fall rates
   localparam logic [7:0] ADDR_ZC   = 8'h2a; // Zero cross gate
   localparam logic [7:0] ADDR_GAIN = 8'h2d; // Manual input gain
   localparam logic [7:0] ADDR_STAT = 8'h30; // Live gain and state readback

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int EN_BIT    = 8;
   localparam int MODE_BIT  = 8;
   localparam int ZC_BIT    = 1;
   localparam int MUTE_BIT  = 6;
   localparam int MZC_BIT   = 7;
   localparam int MAX_LSB   = 3;
   localparam int MIN_LSB   = 0;
   localparam int HOLD_LSB  = 4;
   localparam int RISE_LSB  = 4;
   localparam int FALL_LSB  = 0;
   localparam int GAIN_LSB  = 0;
   localparam int STATE_LSB = 6;

   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [8:0] RST_CFG  = 9'h038;
   localparam logic [8:0] RST_HOLD = 9'h00b;
   localparam logic [8:0] RST_MODE = 9'h032;
   localparam logic [8:0] RST_ZC   = 9'h000;
   localparam logic [8:0] RST_GAIN = 9'h010;

   // ***************************************************
   // Gain steps: eight steps make 6dB
   // ***************************************************
   localparam logic [2:0] GAIN_FILL_LO = 3'h0; // Min code sits on a 6dB line
   localparam logic [2:0] GAIN_FILL_HI = 3'h7; // Max code sits at the top of it

   // ***************************************************
   // Timing, one unit is half the fastest gain step
   // ***************************************************
   localparam int CLK_NS        = 10;
   localparam int UNIT_NS       = 11350;
   localparam int UNIT_CYC      = UNIT_NS / CLK_NS;
   localparam int RATE_TRIM     = 4;   // Cycles added per sample rate code
   localparam int LIM_FALL_UNIT = 2;
   localparam int LIM_RISE_UNIT = 8;
   localparam int NRM_FALL_UNIT = 9;
   localparam int NRM_RISE_UNIT = 36;
   localparam int HOLD_UNIT     = 235;
   localparam logic [3:0] CODE_SAT = 4'ha;

   typedef enum logic [1:0] {
      ALC_IDLE = 2'b00,
      ALC_FALL = 2'b01,
      ALC_HOLD = 2'b11,
      ALC_RISE = 2'b10
   } alc_state_t;

endpackage : alc_pkg

// ---- core/alc_unit_tick.sv ----
// Time unit pulse generator scaled by the sample rate setting
module alc_unit_tick #(
   parameter int CNT_W = 12
) (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic [2:0] sample_rate_select,
   output logic            unit_tick
);

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] period;

   initial begin
      if (alc_pkg::UNIT_CYC + 7 * alc_pkg::RATE_TRIM >= (1 << CNT_W)) begin
         $error("alc_unit_tick: CNT_W too small");
      end
   end

   // Unit snaps to the rate's divider, so it drifts slightly per rate
   assign period = CNT_W'(alc_pkg::UNIT_CYC + alc_pkg::RATE_TRIM * int'(sample_rate_select));

   // ***************************************************
   // Free running divider
   // ***************************************************
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt       <= '0;
         unit_tick <= 1'b0;
      end else if (cnt >= period - 1'b1) begin
         cnt       <= '0;
         unit_tick <= 1'b1;
      end else begin
         cnt       <= cnt + 1'b1;
         unit_tick <= 1'b0;
      end
   end

endmodule : alc_unit_tick

// ---- verif/alc_pga_model.sv ----
// Behavioural model of the input amplifier with its peak detector and zero cross source
module alc_pga_model (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic [5:0] amp_gain,
   input  wire logic       input_amp_mute,
   input  wire logic [5:0] peak_gain,
   input  wire logic       zc_run,
   output logic            level_above,
   output logic            zero_cross
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [5:0] phase;

   // ***************************************************
   // Detector and tone
   // ***************************************************
   // Peaks pass threshold once gain exceeds peak_gain; a muted input carries no signal
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         level_above <= 1'b0;
      end else begin
         level_above <= !input_amp_mute && (amp_gain > peak_gain);
      end
   end

   // Tone crossings every 38 cycles, slow enough that gating visibly delays a step
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase      <= 6'h00;
         zero_cross <= 1'b0;
      end else begin
         phase      <= (phase == 6'h25) ? 6'h00 : phase + 6'h01;
         zero_cross <= zc_run && (phase == 6'h00);
      end
   end
endmodule : alc_pga_model

// ---- verif/alc_gain_ctrl_tb.sv ----
// Self-checking testbench of the level control gain block
module alc_gain_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic       sys_clk;
   logic       sys_rst;
   logic [7:0] reg_addr;
   logic [8:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [8:0] reg_rdata;
   logic [2:0] sample_rate_select;
   logic       level_above;
   logic       zero_cross;
   logic [5:0] amp_gain;
   logic       input_amp_mute;
   logic [5:0] peak_gain;
   logic       zc_run;
   logic [31:0] seed;
   logic [8:0] d;
   int         bad_count;
   int         check_count;
   int         u;
   int         n;
   logic [7:0] ra [5] = '{alc_pkg::ADDR_CFG, alc_pkg::ADDR_HOLD, alc_pkg::ADDR_MODE, alc_pkg::ADDR_ZC,
                          alc_pkg::ADDR_GAIN};
   logic [8:0] rv [5] = '{alc_pkg::RST_CFG, alc_pkg::RST_HOLD, alc_pkg::RST_MODE, alc_pkg::RST_ZC,
                          alc_pkg::RST_GAIN};

   alc_gain_ctrl alc_gain_ctrl_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sample_rate_select(sample_rate_select), .level_above(level_above), .zero_cross(zero_cross),
      .amp_gain(amp_gain), .input_amp_mute(input_amp_mute));

   alc_pga_model alc_pga_model_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .amp_gain(amp_gain),
      .input_amp_mute(input_amp_mute), .peak_gain(peak_gain), .zc_run(zc_run),
      .level_above(level_above), .zero_cross(zero_cross));

   // ***************************************************
   // Helpers
   // ***************************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   // Step gap window, one unit either side because the unit tick runs free
   function automatic logic in_win(input int gap, input int units, input int unit_len);
      return (gap >= (units - 1) * unit_len) && (gap <= (units + 1) * unit_len + 40);
   endfunction : in_win

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [8:0] v);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [8:0] v);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   // Cycles until amp_gain moves, capped at lim
   task automatic step_wait(input int lim, output int cyc);
      logic [5:0] g;
      g   = amp_gain;
      cyc = 0;
      while (amp_gain === g && cyc < lim) begin
         @(posedge sys_clk);
         #1 cyc++;
      end
   endtask : step_wait

   task automatic finish_test;
      $display("Checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   // ***************************************************
   // Clock and watchdog
   // ***************************************************
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Whole run is near 75k cycles; cut off before the 100k cycle budget
   initial begin
      #950000;
      bad_count++;
      finish_test();
   end

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      seed = xs(32'hfff46859);
      sys_rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 9'h000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      sample_rate_select = seed[2:0];
      peak_gain = 6'h3f;
      zc_run = 1'b0;
      bad_count = 0;
      check_count = 0;
      u = alc_pkg::UNIT_CYC + alc_pkg::RATE_TRIM * int'(seed[2:0]);
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      // Reset values, unmapped and read-only places
      for (int i = 0; i < 5; i++) begin
         rd(ra[i], d);
         check("reset_reg", 16'(d), 16'(rv[i]));
      end
      wr(alc_pkg::ADDR_STAT, 9'h1ff);
      rd(alc_pkg::ADDR_STAT, d);
      check("stat_reset", 16'(d), 16'h0010);
      rd(8'h25, d);
      check("unmapped", 16'(d), 16'h0000);
      @(posedge sys_clk);
      #1 check("rdata_idle", 16'(reg_rdata), 16'h0000);
      seed = xs(seed);
      wr(alc_pkg::ADDR_HOLD, {5'h00, seed[3:0]});
      rd(alc_pkg::ADDR_HOLD, d);
      check("hold_rw", 16'(d), {12'h000, seed[3:0]});
      // Disabled: manual writes reach the amplifier
      seed = xs(seed);
      wr(alc_pkg::ADDR_GAIN, {3'b001, seed[5:0]});
      #1 check("man_gain", 16'(amp_gain), 16'(seed[5:0]));
      check("mute", 16'(input_amp_mute), 16'h0001);
      // Mute and zero cross cleared before enabling
      wr(alc_pkg::ADDR_GAIN, 9'h020);
      // Limiter entered directly, gated by zero crossings that do not come yet
      wr(alc_pkg::ADDR_MODE, 9'h100);
      wr(alc_pkg::ADDR_ZC, 9'h002);
      peak_gain <= 6'h00;
      wr(alc_pkg::ADDR_CFG, 9'h138);
      repeat (4 * u) @(posedge sys_clk);
      #1 check("zc_hold", 16'(amp_gain), 16'h0020);
      rd(alc_pkg::ADDR_STAT, d);
      check("stat_fall", 16'(d), 16'h0060);
      zc_run <= 1'b1;
      step_wait(4 * u, n);
      check("lim_fall1", 16'(amp_gain), 16'h001f);
      step_wait(4 * u, n);
      check("lim_fall2", 16'(amp_gain), 16'h001e);
      check("lim_fall_gap", 16'(in_win(n, alc_pkg::LIM_FALL_UNIT, u)), 16'h0001);
      // Quiet input: climb back to the captured starting gain and stop there
      wr(alc_pkg::ADDR_ZC, 9'h000);
      peak_gain <= 6'h3f;
      step_wait(11 * u, n);
      check("lim_rise1", 16'(amp_gain), 16'h001f);
      step_wait(11 * u, n);
      check("lim_rise2", 16'(amp_gain), 16'h0020);
      check("lim_rise_gap", 16'(in_win(n, alc_pkg::LIM_RISE_UNIT, u)), 16'h0001);
      step_wait(10 * u, n);
      check("lim_ceiling", 16'(amp_gain), 16'h0020);
      // Enabled manual write is held off; disabling freezes the gain
      wr(alc_pkg::ADDR_GAIN, 9'h005);
      repeat (3) @(posedge sys_clk);
      #1 check("man_refused", 16'(amp_gain), 16'h0020);
      wr(alc_pkg::ADDR_CFG, 9'h038);
      peak_gain <= 6'h00;
      repeat (3 * u) @(posedge sys_clk);
      #1 check("frozen", 16'(amp_gain), 16'h0020);
      rd(alc_pkg::ADDR_STAT, d);
      check("stat_idle", 16'(d), 16'h0020);
      // Normal mode falls at the slower pace down to the minimum code
      wr(alc_pkg::ADDR_GAIN, 9'h00a);
      #1 check("man_gain2", 16'(amp_gain), 16'h000a);
      wr(alc_pkg::ADDR_MODE, 9'h000);
      wr(alc_pkg::ADDR_CFG, 9'h139);
      step_wait(11 * u, n);
      check("nrm_fall1", 16'(amp_gain), 16'h0009);
      step_wait(11 * u, n);
      check("nrm_fall2", 16'(amp_gain), 16'h0008);
      check("nrm_fall_gap", 16'(in_win(n, alc_pkg::NRM_FALL_UNIT, u)), 16'h0001);
      step_wait(11 * u, n);
      check("nrm_floor", 16'(amp_gain), 16'h0008);
      finish_test();
   end
endmodule : alc_gain_ctrl_tb
